// >>> rtl/srg_ctrl.sv
// Purpose: gate sequencing of a synchronous-rectifier driver
// Assumes: comparator outputs arrive as digital levels
// Notes: enable voltage arrives as an 8-bit code
`timescale 1ns/1ps
`include "srg_map.svh"

// Summary of operation
// [R1] gate on when armed and turnon crossed
// [R2] gate off at turnoff crossing or force
// [R3] min on-time blanks the turnoff detector
// [R4] rearm crossing starts min off-time blanking
// [R5] turn on only armed, after off-time
// [R6] short conduction sets light latch, blanks pulse
// [R7] conduction compared every cycle, blanked too
// [R8] long conduction clears latch, back to run
// [R9] lockout: pulldown on, source off, gate low
// [R10] supply lockout with hysteresis
// [R11] enable with hysteresis outside lockout
// [R12] low enable forces gate low, sleeps
// [R13] wake waits 25 us, enters light-load
// [R14] external enable drive held high 100 ns; the code has no such timer, en_src_r is simply high outside lockout
// [R15] off-time inverse to enable voltage
// [R16] bad on-time resistor forces fault shutdown
// [R17] open enable gives 0.65 us off-time
// [R18] held force input keeps gate low
// [R19] synchronised inputs, down-counter intervals
module srg_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire srg_pkg::srg_cmp_type cmp_in,
  input wire logic [7:0] en_level,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic gate_r,
  output logic en_src_r,
  output logic en_pd_r,
  output logic irq_r
);
  // ==============================
  // constants
  localparam int SETTLE_CYC = `SRG_SETTLE_NS / `SRG_CLK_NS;
  localparam int OFF_MIN_CYC = (`SRG_OFF_MIN_NS + `SRG_CLK_NS - 1) / `SRG_CLK_NS;
  localparam int CW = $bits(srg_pkg::srg_cmp_type);

  // ==============================
  // synchronisers
  logic [CW-1:0] sync1_r; // first stage, read only by second
  logic [CW-1:0] sync2_r; // second stage
  srg_pkg::srg_cmp_type sy; // usable comparator view
  genvar gi;
  generate
    for (gi = 0; gi < CW; gi++) begin : g_sync
      // two flops per comparator bit [R19]
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= cmp_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate
  assign sy = srg_pkg::srg_cmp_type'(sync2_r);

  // ==============================
  // state
  srg_pkg::srg_mode_type mode_r; // device mode
  srg_pkg::srg_mode_type mode_nxt;
  srg_pkg::srg_cyc_type cyc_r; // cycle phase
  logic sup_ok_r; // out of lockout
  logic en_ok_r; // enabled
  logic light_r; // light-load latch
  logic short_r; // turnoff seen inside min on-time
  logic [7:0] on_cnt_r; // min on-time down-counter
  logic [15:0] off_cnt_r; // min off-time down-counter
  logic [9:0] settle_cnt_r; // wake settling counter
  logic [7:0] ontime_r; // programmed on-time cycles
  logic [`SRG_EV_W-1:0] stat_r; // sticky events
  logic [`SRG_EV_W-1:0] mask_r; // interrupt mask
  logic [`SRG_EV_W-1:0] ev; // event pulses
  logic cyc_end; // conduction ended this cycle
  logic short_now; // this conduction was short
  logic active; // run or light-load
  logic [15:0] off_cyc; // off-time for this cycle

  assign active = (mode_r == srg_pkg::M_RUN) || (mode_r == srg_pkg::M_LIGHT);

  // ==============================
  // supply and enable hysteresis
  // supply latch set above upper, cleared below lower [R10]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sup_ok_r <= 1'b0;
    end else if (sy.sup_hi) begin
      sup_ok_r <= 1'b1;
    end else if (!sy.sup_lo) begin
      sup_ok_r <= 1'b0;
    end
  end

  // enable latch; ignored in lockout [R11] [R9]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_ok_r <= 1'b0;
    end else if (!sup_ok_r) begin
      en_ok_r <= 1'b0;
    end else if (sy.en_hi) begin
      en_ok_r <= 1'b1;
    end else if (!sy.en_lo) begin
      en_ok_r <= 1'b0;
    end
  end

  // ==============================
  // mode sequencing
  // lockout beats fault beats sleep
  always_comb begin
    mode_nxt = mode_r;
    if (!sup_ok_r || !sy.sup_lo) begin
      mode_nxt = srg_pkg::M_LOCK; // [R10]
    end else if (mode_r == srg_pkg::M_FAULT || sy.res_bad) begin
      // fault stays until lockout
      mode_nxt = srg_pkg::M_FAULT; // [R16]
    end else if (!en_ok_r || !sy.en_lo) begin
      // overrides any timer in progress, incl. shorted pin
      mode_nxt = srg_pkg::M_SLEEP; // [R12] [R17]
    end else begin
      case (mode_r)
        srg_pkg::M_LOCK, srg_pkg::M_SLEEP: begin
          mode_nxt = srg_pkg::M_SETTLE;
        end
        srg_pkg::M_SETTLE: begin
          // wake goes to light-load, not run [R13]
          if (settle_cnt_r == 10'h0) begin
            mode_nxt = srg_pkg::M_LIGHT;
          end
        end
        srg_pkg::M_RUN, srg_pkg::M_LIGHT: begin
          mode_nxt = light_r ? srg_pkg::M_LIGHT : srg_pkg::M_RUN;
          if (cyc_end) begin
            // verdict takes effect for the next cycle [R6] [R8]
            mode_nxt = short_now ? srg_pkg::M_LIGHT : srg_pkg::M_RUN;
          end
        end
        default: begin
          mode_nxt = srg_pkg::M_LOCK;
        end
      endcase
    end
  end

  // mode register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= srg_pkg::M_LOCK;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // settle counter loads on entry, counts down [R13]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_cnt_r <= 10'(SETTLE_CYC - 1);
    end else if (mode_r != srg_pkg::M_SETTLE) begin
      settle_cnt_r <= 10'(SETTLE_CYC - 1);
    end else if (settle_cnt_r != 10'h0) begin
      settle_cnt_r <= settle_cnt_r - 10'h1;
    end
  end

  // lockout pin handling: source off, pulldown on [R9]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_src_r <= 1'b0;
      en_pd_r <= 1'b1;
    end else begin
      en_src_r <= (mode_nxt != srg_pkg::M_LOCK);
      en_pd_r <= (mode_nxt == srg_pkg::M_LOCK);
    end
  end

  // ==============================
  // off-time from enable level
  // inverse of the code, clamped to the open-pin floor [R15] [R17]
  always_comb begin
    off_cyc = 16'(OFF_MIN_CYC);
    if (en_level != 8'h0 && (`SRG_OFF_K / en_level) > 16'(OFF_MIN_CYC)) begin
      off_cyc = 16'(`SRG_OFF_K / en_level);
    end
  end

  // ==============================
  // switching cycle
  // conduction ends at turnoff; a live gate ignores it while blanked [R3] [R7]
  assign cyc_end = (cyc_r == srg_pkg::C_COND) && sy.off_cross && (on_cnt_r == 8'h0 || !gate_r);
  assign short_now = short_r || (on_cnt_r != 8'h0);

  // cycle phase machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_r <= srg_pkg::C_WAIT;
    end else if (!active) begin
      cyc_r <= srg_pkg::C_WAIT;
    end else begin
      case (cyc_r)
        srg_pkg::C_WAIT: begin
          // rearm crossing after turnoff [R4]
          if (sy.rearm) begin
            cyc_r <= srg_pkg::C_OFFBLANK;
          end
        end
        srg_pkg::C_OFFBLANK: begin
          // turnon detector blanked; arm on expiry [R4] [R5]
          if (off_cnt_r == 16'h0) begin
            cyc_r <= srg_pkg::C_ARMED;
          end
        end
        srg_pkg::C_ARMED: begin
          // an early request is simply still pending here [R5]
          if (sy.on_cross) begin
            cyc_r <= srg_pkg::C_COND;
          end
        end
        srg_pkg::C_COND: begin
          if (cyc_end) begin
            cyc_r <= srg_pkg::C_WAIT;
          end
        end
        default: begin
          cyc_r <= srg_pkg::C_WAIT;
        end
      endcase
    end
  end

  // off-time down-counter, loaded on rearm [R4] [R19]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      off_cnt_r <= 16'h0;
    end else if (cyc_r == srg_pkg::C_WAIT) begin
      off_cnt_r <= off_cyc - 16'h1;
    end else if (cyc_r == srg_pkg::C_OFFBLANK && off_cnt_r != 16'h0) begin
      off_cnt_r <= off_cnt_r - 16'h1;
    end
  end

  // on-time counter runs for issued and blanked pulses alike [R7] [R19]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      on_cnt_r <= 8'h0;
    end else if (cyc_r == srg_pkg::C_ARMED) begin
      on_cnt_r <= ontime_r;
    end else if (cyc_r == srg_pkg::C_COND && on_cnt_r != 8'h0) begin
      on_cnt_r <= on_cnt_r - 8'h1;
    end
  end

  // turnoff seen during min on-time marks a short conduction [R6]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      short_r <= 1'b0;
    end else if (cyc_r != srg_pkg::C_COND) begin
      short_r <= 1'b0;
    end else if (sy.off_cross && on_cnt_r != 8'h0) begin
      short_r <= 1'b1;
    end
  end

  // light-load latch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      light_r <= 1'b0;
    end else if (mode_r == srg_pkg::M_SETTLE) begin
      light_r <= 1'b1; // [R13]
    end else if (active && cyc_end) begin
      light_r <= short_now; // [R6] [R8]
    end
  end

  // ==============================
  // gate output
  // pulse only in run mode, dropped by force at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_r <= 1'b0;
    end else if (mode_nxt != srg_pkg::M_RUN || !sy.force_n) begin
      gate_r <= 1'b0; // [R2] [R9] [R12] [R16] [R18]
    end else if (cyc_r == srg_pkg::C_ARMED && sy.on_cross && !light_r) begin
      gate_r <= 1'b1; // [R1] [R5]
    end else if (cyc_end) begin
      gate_r <= 1'b0; // [R2] [R3]
    end
  end

  // ==============================
  // events and interrupt
  always_comb begin
    ev = '0;
    ev[`SRG_EV_LIGHT_IN] = (mode_nxt == srg_pkg::M_LIGHT) && (mode_r == srg_pkg::M_RUN);
    ev[`SRG_EV_LIGHT_OUT] = (mode_nxt == srg_pkg::M_RUN) && (mode_r == srg_pkg::M_LIGHT);
    ev[`SRG_EV_FAULT] = (mode_nxt == srg_pkg::M_FAULT) && (mode_r != srg_pkg::M_FAULT);
    ev[`SRG_EV_LOCK] = (mode_nxt == srg_pkg::M_LOCK) && (mode_r != srg_pkg::M_LOCK);
    ev[`SRG_EV_SLEEP] = (mode_nxt == srg_pkg::M_SLEEP) && (mode_r != srg_pkg::M_SLEEP);
  end

  // sticky status, write one to clear; a new event wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_r <= `SRG_STATUS_RST;
    end else if (wr && addr == `SRG_OFS_STATUS) begin
      stat_r <= (stat_r & ~wdata[`SRG_EV_W-1:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r);
    end
  end

  // ==============================
  // register writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_r <= `SRG_MASK_RST;
      ontime_r <= `SRG_ONTIME_RST;
    end else if (wr) begin
      if (addr == `SRG_OFS_MASK) begin
        mask_r <= wdata[`SRG_EV_W-1:0];
      end
      if (addr == `SRG_OFS_ONTIME) begin
        // programmed min on-time in cycles
        ontime_r <= wdata[7:0];
      end
    end
  end

  // register reads; unmapped reads as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h0;
    end else if (rd) begin
      case (addr)
        `SRG_OFS_STATUS: rdata <= {27'h0, stat_r};
        `SRG_OFS_MASK: rdata <= {27'h0, mask_r};
        `SRG_OFS_ONTIME: rdata <= {24'h0, ontime_r};
        `SRG_OFS_MODE: rdata <= {24'h0, light_r, gate_r, cyc_r, 1'b0, mode_r};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  // ==============================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_gate_armed: assert property ($rose(gate_r) |-> $past(cyc_r) == srg_pkg::C_ARMED) // [R5]
    else $error("gate rose while not armed");
  a_turnon_cause: assert property ($rose(gate_r) |-> $past(sy.on_cross) && !$past(light_r)) // [R1]
    else $error("gate rose without turnon crossing");
  a_on_blank: assert property (gate_r && on_cnt_r != 8'h0 && sy.force_n // [R3]
    && mode_nxt == srg_pkg::M_RUN |=> gate_r)
    else $error("gate dropped inside min on-time");
  a_force_low: assert property (!sy.force_n |=> !gate_r) // [R18]
    else $error("gate high while forced off");
  a_lock_pins: assert property (mode_r == srg_pkg::M_LOCK |-> !gate_r && en_pd_r && !en_src_r) // [R9]
    else $error("lockout pin state wrong");
  a_sleep_fast: assert property (active && !sy.en_lo && sy.sup_lo && !sy.res_bad // [R12]
    |=> mode_r == srg_pkg::M_SLEEP && !gate_r)
    else $error("no immediate sleep");
  a_settle_light: assert property (mode_r == srg_pkg::M_SETTLE |=> mode_r != srg_pkg::M_RUN) // [R13]
    else $error("settle went straight to run");
  a_light_quiet: assert property (mode_r == srg_pkg::M_LIGHT && $past(mode_r) == srg_pkg::M_LIGHT // [R6]
    |-> !gate_r)
    else $error("gate pulse in light-load");
  a_light_exit: assert property (cyc_end && !short_now && mode_r == srg_pkg::M_LIGHT // [R8]
    && mode_nxt != srg_pkg::M_SLEEP && mode_nxt != srg_pkg::M_LOCK && mode_nxt != srg_pkg::M_FAULT
    |=> mode_r == srg_pkg::M_RUN && !light_r)
    else $error("light-load not left");
  a_fault_low: assert property (mode_r == srg_pkg::M_FAULT |-> !gate_r) // [R16]
    else $error("gate high in fault");

  c_run_pulse: cover property ($rose(gate_r) ##[1:200] $fell(gate_r));
  c_to_light: cover property (mode_r == srg_pkg::M_RUN ##1 mode_r == srg_pkg::M_LIGHT);
  c_to_run: cover property (mode_r == srg_pkg::M_LIGHT ##1 mode_r == srg_pkg::M_RUN);
  c_fault: cover property (mode_r == srg_pkg::M_FAULT);
endmodule // srg_ctrl

// >>> rtl/srg_map.svh
// Purpose: constants of the rectifier gate controller
// Assumes: 20 MHz clock, register words at byte addresses
// Notes: definitions only
`ifndef SRG_MAP_SVH
`define SRG_MAP_SVH
// ==============================
// timing
`define SRG_CLK_NS 50
`define SRG_SETTLE_NS 25000
`define SRG_OFF_MIN_NS 650
// ==============================
// register offsets
`define SRG_OFS_STATUS 4'h0
`define SRG_OFS_MASK 4'h4
`define SRG_OFS_ONTIME 4'h8
`define SRG_OFS_MODE 4'hc
// ==============================
// status bit positions
`define SRG_EV_LIGHT_IN 0
`define SRG_EV_LIGHT_OUT 1
`define SRG_EV_FAULT 2
`define SRG_EV_LOCK 3
`define SRG_EV_SLEEP 4
`define SRG_EV_W 5
// ==============================
// reset values
`define SRG_STATUS_RST 5'h00
`define SRG_MASK_RST 5'h00
`define SRG_ONTIME_RST 8'h3c
// off-time scale: cycles times enable code
`define SRG_OFF_K 16'h1e78
`endif

// >>> rtl/srg_pkg.sv
// Purpose: types of the rectifier gate controller
// Assumes: constants live in srg_map.svh
// Notes: no logic here
package srg_pkg;
  // ==============================
  // synchronised comparator results
  typedef struct packed {
    logic sup_hi;    // supply above upper lockout threshold
    logic sup_lo;    // supply above lower lockout threshold
    logic en_hi;     // enable above upper threshold
    logic en_lo;     // enable above lower threshold
    logic on_cross;  // vds below turnon_threshold
    logic off_cross; // vds above turnoff_threshold
    logic rearm;     // drain above rearm_threshold
    logic force_n;   // forced-turnoff input, low = force
    logic res_bad;   // ontime_resistor out of range
  } srg_cmp_type;
  // ==============================
  // device modes
  typedef enum logic [2:0] {
    M_LOCK, M_SLEEP, M_SETTLE, M_RUN, M_LIGHT, M_FAULT
  } srg_mode_type;
  // switching-cycle phases
  typedef enum logic [1:0] {
    C_WAIT, C_OFFBLANK, C_ARMED, C_COND
  } srg_cyc_type;
endpackage

// >>> verif/srg_fet_model.sv
// Purpose: behavioural power switch with drain and source sensing
// Assumes: a switching cycle is drain high, current flow, then idle ringing
// Notes: lengths are clock cycles; outputs are raw comparator levels
`timescale 1ns/1ps
module srg_fet_model (
  input wire logic clk,
  input wire logic go,
  input wire logic gate,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] cond_len,
  output logic on_cross,
  output logic off_cross,
  output logic rearm
);
  // ==============================
  // switching cycle sequencer
  logic [1:0] ph_r = 2'h0; // 0 idle ringing, 1 drain high, 2 current flow
  logic [7:0] cnt_r = 8'h00; // cycles left in this phase
  logic [7:0] cond_r = 8'h00; // flow length taken at cycle start
  // lengths are latched so a mid-cycle change never splits a cycle
  always @(posedge clk) begin
    if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else if (ph_r == 2'h1) begin
      ph_r <= 2'h2;
      cnt_r <= cond_r;
    end else if (ph_r == 2'h2) begin
      ph_r <= 2'h0;
      cnt_r <= 8'h14;
    end else if (go) begin
      ph_r <= 2'h1;
      cnt_r <= hi_len;
      cond_r <= cond_len;
    end
  end
  // ==============================
  // sense comparator levels; all stand still while idle
  assign rearm = (ph_r == 2'h1); // drain well above output
  // a closed channel lifts vds above the turnon level
  assign on_cross = (ph_r == 2'h2) && !gate;
  assign off_cross = (ph_r != 2'h2); // no reverse current outside flow
endmodule // srg_fet_model

// >>> verif/testbench.sv
// Purpose: self-checking bench of the rectifier gate controller
// Assumes: switch model drives the drain and source comparators
// Notes: supply, enable, force and fault levels are driven here
`timescale 1ns/1ps
`include "srg_map.svh"
module testbench;
  logic clk, rst_b, wr, rd, go, sup_hi, sup_lo, en_hi, en_lo, force_n, res_bad, on_x, off_x, rearm;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [7:0] en_level, hi_len, cond_len;
  logic gate_r, en_src_r, en_pd_r, irq_r;
  logic gate_q = 1'b0;
  logic rearm_q = 1'b0;
  int bad_count, comparisons, p0;
  int cyc = 0, t_arm = 0, gap = 0, wid_c = 0, width = 0, pulses = 0; // bench measures
  srg_pkg::srg_cmp_type cmp;
  // register offset beside its reset value
  typedef struct { logic [3:0] a; logic [31:0] e; } srg_row_type;
  srg_row_type rows [4] = '{'{`SRG_OFS_MASK, 32'h0}, '{`SRG_OFS_ONTIME, 32'h3c}, '{`SRG_OFS_MODE, 32'h0},
    '{4'h2, 32'h0}};
  assign cmp = '{sup_hi:sup_hi, sup_lo:sup_lo, en_hi:en_hi, en_lo:en_lo, on_cross:on_x, off_cross:off_x,
    rearm:rearm, force_n:force_n, res_bad:res_bad};
  srg_ctrl DUT (.clk(clk), .rst_b(rst_b), .cmp_in(cmp), .en_level(en_level), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .gate_r(gate_r), .en_src_r(en_src_r), .en_pd_r(en_pd_r), .irq_r(irq_r));
  srg_fet_model FET (.clk(clk), .go(go), .gate(gate_r), .hi_len(hi_len), .cond_len(cond_len),
    .on_cross(on_x), .off_cross(off_x), .rearm(rearm));
  // ==============================
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==============================
  // gate monitor: pulse count, width, arm-to-gate gap, hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    gate_q <= gate_r;
    rearm_q <= rearm;
    wid_c <= gate_r ? wid_c + 1 : 0;
    if (rearm && !rearm_q) t_arm <= cyc;
    if (gate_r && !gate_q) pulses <= pulses + 1;
    if (gate_r && !gate_q) gap <= cyc - t_arm;
    if (!gate_r && gate_q) width <= wid_c;
    if (cyc == 8000) begin
      bad_count++;
      $display("Error timeout expected done seen running");
      print_verdict();
    end
  end
  // ==============================
  // checks and bus cycles
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic in_range(input string n, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("Error %s expected %0d to %0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    // hand back on a rising edge so callers drive inputs there
    @(posedge clk);
  endtask
  task automatic mode_is(input srg_pkg::srg_mode_type m);
    bus_rd(`SRG_OFS_MODE);
    chk("mode", {29'h0, m}, {29'h0, v[2:0]});
  endtask
  // settling wait of 500 cycles, then light-load mode
  task automatic wake_chk;
    repeat (100) @(posedge clk);
    mode_is(srg_pkg::M_SETTLE);
    chk("gate", 32'h0, {31'h0, gate_r});
    repeat (450) @(posedge clk);
    mode_is(srg_pkg::M_LIGHT);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==============================
  // main sequence
  initial begin
    {rst_b, wr, rd, go, sup_hi, sup_lo, en_hi, en_lo, res_bad} = 9'h000;
    force_n = 1'b1;
    addr = 4'h0;
    wdata = 32'h0;
    en_level = 8'h00; // open pin, shortest off-time
    hi_len = 8'h14;
    cond_len = 8'h28;
    bad_count = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      bus_rd(rows[i].a);
      chk("register", rows[i].e, v);
    end
    $display("test registers done");
    en_hi <= 1'b1;
    en_lo <= 1'b1;
    sup_lo <= 1'b1;
    repeat (10) @(posedge clk);
    mode_is(srg_pkg::M_LOCK);
    chk("pulldown", 32'h1, {31'h0, en_pd_r});
    chk("source", 32'h0, {31'h0, en_src_r});
    sup_hi <= 1'b1;
    wake_chk();
    chk("source", 32'h1, {31'h0, en_src_r});
    chk("pulldown", 32'h0, {31'h0, en_pd_r});
    $display("test power up done");
    // both levels between thresholds from here on: hysteresis holds them
    sup_hi <= 1'b0;
    en_hi <= 1'b0;
    bus_wr(`SRG_OFS_ONTIME, 32'ha);
    go <= 1'b1;
    repeat (400) @(posedge clk);
    mode_is(srg_pkg::M_RUN);
    chk("source", 32'h1, {31'h0, en_src_r});
    in_range("width", 36, 44, width);
    hi_len <= 8'h05; // flow starts before the off-time ends
    repeat (300) @(posedge clk);
    in_range("gap", 13, 21, gap);
    en_level <= 8'd120;
    cond_len <= 8'd100;
    repeat (600) @(posedge clk);
    in_range("gap", 65, 73, gap);
    en_level <= 8'h00;
    hi_len <= 8'h14;
    cond_len <= 8'h28;
    $display("test timing done");
    force_n <= 1'b0;
    repeat (5) @(posedge clk);
    p0 = pulses;
    repeat (200) @(posedge clk);
    chk("pulses", p0, pulses);
    force_n <= 1'b1;
    repeat (200) @(posedge clk);
    chk("pulses resumed", 32'h1, {31'h0, pulses > p0});
    mode_is(srg_pkg::M_RUN);
    $display("test force done");
    bus_wr(`SRG_OFS_STATUS, 32'h1f);
    bus_wr(`SRG_OFS_MASK, 32'h1 << `SRG_EV_LIGHT_IN);
    cond_len <= 8'h04; // flow shorter than the minimum on-time
    repeat (300) @(posedge clk);
    mode_is(srg_pkg::M_LIGHT);
    in_range("width", 10, 13, width);
    chk("irq", 32'h1, {31'h0, irq_r});
    bus_rd(`SRG_OFS_STATUS);
    chk("status", 32'h1, {31'h0, v[`SRG_EV_LIGHT_IN]});
    p0 = pulses;
    repeat (300) @(posedge clk);
    chk("pulses", p0, pulses);
    bus_wr(`SRG_OFS_MASK, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq_r});
    bus_wr(`SRG_OFS_MASK, 32'h1 << `SRG_EV_LIGHT_IN);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq_r});
    bus_wr(`SRG_OFS_STATUS, 32'h1 << `SRG_EV_LIGHT_IN);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq_r});
    cond_len <= 8'h28;
    repeat (400) @(posedge clk);
    mode_is(srg_pkg::M_RUN);
    $display("test light load done");
    while (!gate_r) @(posedge clk);
    en_lo <= 1'b0; // drop enable in mid pulse
    repeat (4) @(posedge clk);
    chk("gate", 32'h0, {31'h0, gate_r});
    mode_is(srg_pkg::M_SLEEP);
    // switching stops so light-load is not left before the wake check
    go <= 1'b0;
    en_hi <= 1'b1;
    en_lo <= 1'b1;
    wake_chk();
    $display("test sleep done");
    res_bad <= 1'b1;
    repeat (6) @(posedge clk);
    res_bad <= 1'b0;
    repeat (6) @(posedge clk);
    mode_is(srg_pkg::M_FAULT);
    chk("gate", 32'h0, {31'h0, gate_r});
    go <= 1'b0;
    sup_lo <= 1'b0;
    repeat (10) @(posedge clk);
    mode_is(srg_pkg::M_LOCK);
    chk("pulldown", 32'h1, {31'h0, en_pd_r});
    chk("source", 32'h0, {31'h0, en_src_r});
    // light-load exit, sleep, fault and lockout events since the last clear
    p0 = (1 << `SRG_EV_LIGHT_OUT) | (1 << `SRG_EV_SLEEP) | (1 << `SRG_EV_FAULT) | (1 << `SRG_EV_LOCK);
    bus_rd(`SRG_OFS_STATUS);
    chk("status", p0, v);
    $display("test fault done");
    print_verdict();
  end
endmodule // testbench
